// [verilog/gb_params.svh]
`ifndef GB_PARAMS_SVH
`define GB_PARAMS_SVH

// Timing of one peripheral bus strobe.
`define GB_CLK_PERIOD_NS 20
`define GB_STROBE_MIN_NS 80
`define GB_STROBE_CYCLES ((`GB_STROBE_MIN_NS + `GB_CLK_PERIOD_NS - 1) / `GB_CLK_PERIOD_NS)
`define GB_CNT_W 3

// Code buffer shape.
`define GB_FIFO_DEPTH 8
`define GB_FIFO_WIDTH 32

// Pin levels and reset values.
`define GB_SEL_NONE 4'hF
`define GB_SEL_ONE 4'h1
`define GB_ADDR_ZERO 3'h0
`define GB_BYTE_ZERO 8'h00
`define GB_IRQ_ZERO 2'h0

`endif

// [verilog/gb_pkg.sv]
package gb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } gb_state_t;

  typedef struct packed {
    logic [3:0] sel_n;
    logic [2:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] dout;
    logic doe;
  } periph_pins_t;

  typedef struct packed {
    logic write;
    logic [1:0] dev;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_acc_t;

endpackage

// [verilog/code_fifo.sv]
`include "gb_params.svh"

module code_fifo #(
  parameter int unsigned WIDTH = `GB_FIFO_WIDTH,
  parameter int unsigned DEPTH = `GB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  // Room is kept as its own flip-flop so the fill-side ready needs no gate after the register.
  logic room_q, room_d, empty_q, empty_d;
  logic push, pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    push = i_valid && room_q;
    pop = i_ready && !empty_q;
    wr_d = push ? next_ptr(wr_q) : wr_q;
    rd_d = pop ? next_ptr(rd_q) : rd_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    if (i_clear) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
    room_d = (cnt_d != FULL_CNT);
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      room_q <= room_d;
      empty_q <= empty_d;
    end
  end

  // The storage itself needs no reset; only words marked valid are read.
  always_ff @(posedge i_clk) begin
    if (push && !i_clear) begin
      mem_q[wr_q] <= i_data;
    end
  end

  assign o_ready = room_q;
  assign o_valid = !empty_q;
  assign o_data = mem_q[rd_q];
endmodule

// [verilog/guest_bus_master_port.sv]
// What this block does
// [RULE1] Four separate active-low select outputs, one per attached peripheral.
// [RULE2] Three address lines pick a register inside the selected peripheral.
// [RULE3] Eight-bit data lines driven on writes and released on reads.
// [RULE4] Separate read and write strobes, each low for the whole access; here each is low four clocks (80 ns) plus any wait, not in setup or hold.
// [RULE5] Streamed code writes pause while the ready input is low.
// [RULE6] A low wait input keeps the current cycle open until it rises.
// [RULE7] Two peripheral interrupt inputs are caught on rising edges only.
// [RULE8] A dedicated channel moves memory data to one peripheral.
// [RULE9] Streamed data passes an eight-word by 32-bit buffer.
// [RULE10] Host reset low floats all outputs; its release restarts from power-on state (the last read data is kept).
// [RULE11] The system holds host reset low for at least three clocks.
// [RULE12] Host interrupt is an open-drain low held while a request persists.
// [RULE13] Writing one clears or sets a status bit; writing zero changes nothing.
// [RULE14] Host accesses become peripheral read or write cycles to the addressed device.
// [RULE15] Streaming is the main task; host accesses may slip between its transfers.
// [RULE16] At most one select per cycle; address and data stable under strobe.
`include "gb_params.svh"

module guest_bus_master_port #(
  parameter int unsigned FIFO_WIDTH = `GB_FIFO_WIDTH,
  parameter int unsigned FIFO_DEPTH = `GB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_host_reset_n,
  // Host single accesses
  input wire logic i_acc_req,
  input wire gb_pkg::host_acc_t i_acc,
  output logic o_acc_ack,
  output logic [7:0] o_acc_rdata,
  // Code stream
  input wire logic i_dma_en,
  input wire logic [1:0] i_dma_dev,
  input wire logic [2:0] i_dma_addr,
  input wire logic i_dma_valid,
  input wire logic [FIFO_WIDTH-1:0] i_dma_word,
  output logic o_dma_ready,
  // Interrupt status
  input wire logic [1:0] i_irq_clear,
  input wire logic [1:0] i_irq_set,
  output logic [1:0] o_irq_status,
  output logic o_host_irq_out,
  output logic o_host_irq_oe,
  // Peripheral bus pins
  output gb_pkg::periph_pins_t o_periph,
  output logic o_pins_oe,
  input wire logic [7:0] i_periph_data,
  input wire logic i_periph_ready,
  input wire logic i_periph_wait_n,
  input wire logic [1:0] i_periph_irq
);
  import gb_pkg::*;

  localparam int unsigned BYTES = FIFO_WIDTH / 8;
  localparam int unsigned BW = (BYTES > 1) ? $clog2(BYTES) : 1;
  localparam logic [BW-1:0] BYTE_LAST = BW'(BYTES - 1);
  localparam logic [`GB_CNT_W-1:0] STROBE_LAST = `GB_CNT_W'(`GB_STROBE_CYCLES - 1);
  localparam periph_pins_t PINS_IDLE = '{`GB_SEL_NONE, `GB_ADDR_ZERO, 1'b1, 1'b1, `GB_BYTE_ZERO, 1'b0};

  // Two-stage synchronisers for every pin input.
  logic [12:0] sync1_q, sync2_q;
  logic host_on, ready_s, wait_n_s;
  logic [1:0] irq_s;
  logic [7:0] data_s;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= {1'b0, 1'b0, 1'b1, `GB_IRQ_ZERO, `GB_BYTE_ZERO};
      sync2_q <= {1'b0, 1'b0, 1'b1, `GB_IRQ_ZERO, `GB_BYTE_ZERO};
    end else begin
      sync1_q <= {i_host_reset_n, i_periph_ready, i_periph_wait_n, i_periph_irq, i_periph_data};
      sync2_q <= sync1_q;
    end
  end

  assign {host_on, ready_s, wait_n_s, irq_s, data_s} = sync2_q;

  // Code buffer.
  logic fifo_valid, fifo_pop;
  logic [FIFO_WIDTH-1:0] fifo_word;

  code_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_code_fifo ( // [RULE9]
    .i_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clear(!host_on),
    .i_valid(i_dma_valid),
    .i_data(i_dma_word),
    .o_ready(o_dma_ready),
    .o_valid(fifo_valid),
    .o_data(fifo_word),
    .i_ready(fifo_pop)
  );

  function automatic logic [7:0] pick_byte(input logic [FIFO_WIDTH-1:0] w, input logic [BW-1:0] i);
    pick_byte = w[i*8 +: 8];
  endfunction

  function automatic logic [3:0] one_sel(input logic [1:0] dev);
    one_sel = ~(`GB_SEL_ONE << dev);
  endfunction

  // Bus cycle engine.
  gb_state_t state_q, state_d;
  logic [`GB_CNT_W-1:0] cnt_q, cnt_d;
  periph_pins_t pins_q, pins_d;
  logic is_dma_q, is_dma_d, is_read_q, is_read_d, ack_q, ack_d;
  logic [BW-1:0] bidx_q, bidx_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pins_d = pins_q;
    is_dma_d = is_dma_q;
    is_read_d = is_read_q;
    bidx_d = bidx_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    fifo_pop = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (i_acc_req && !ack_q) begin // [RULE14] [RULE15]
          pins_d.sel_n = one_sel(i_acc.dev); // [RULE1]
          pins_d.addr = i_acc.addr; // [RULE2]
          pins_d.dout = i_acc.wdata;
          pins_d.doe = i_acc.write; // [RULE3]
          is_read_d = !i_acc.write;
          is_dma_d = 1'b0;
          state_d = ST_SETUP;
        end else if (i_dma_en && fifo_valid && ready_s) begin // [RULE5] [RULE8]
          pins_d.sel_n = one_sel(i_dma_dev); // [RULE1]
          pins_d.addr = i_dma_addr;
          pins_d.dout = pick_byte(fifo_word, bidx_q);
          pins_d.doe = 1'b1;
          is_read_d = 1'b0;
          is_dma_d = 1'b1;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        pins_d.rd_n = !is_read_q; // [RULE4]
        pins_d.wr_n = is_read_q;
        cnt_d = STROBE_LAST;
        state_d = ST_STROBE;
      end
      ST_STROBE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (wait_n_s) begin // [RULE6]
          pins_d.rd_n = 1'b1;
          pins_d.wr_n = 1'b1;
          if (is_read_q) begin
            rdata_d = data_s;
          end
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        pins_d = PINS_IDLE; // [RULE16]
        state_d = ST_IDLE;
        if (is_dma_q) begin
          bidx_d = (bidx_q == BYTE_LAST) ? '0 : bidx_q + 1'b1;
          fifo_pop = (bidx_q == BYTE_LAST);
        end else begin
          ack_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Holding here while the host reset is low gives the power-on state at release, except for the last read data in rdata_q.
    if (!host_on) begin // [RULE10]
      state_d = ST_IDLE;
      pins_d = PINS_IDLE;
      bidx_d = '0;
      ack_d = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      pins_q <= PINS_IDLE;
      is_dma_q <= 1'b0;
      is_read_q <= 1'b0;
      bidx_q <= '0;
      rdata_q <= `GB_BYTE_ZERO;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      is_dma_q <= is_dma_d;
      is_read_q <= is_read_d;
      bidx_q <= bidx_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // Interrupt edges and status.
  logic [1:0] irq_prev_q, irq_prev_d, status_q, status_d, irq_rise;
  logic irq_oe_q, irq_oe_d, pins_oe_q, pins_oe_d;

  always_comb begin
    irq_rise = irq_s & ~irq_prev_q; // [RULE7]
    irq_prev_d = irq_s;
    // A new edge or a set wins over a clear in the same cycle.
    status_d = (status_q & ~i_irq_clear) | i_irq_set | irq_rise; // [RULE13]
    if (!host_on) begin
      status_d = `GB_IRQ_ZERO;
    end
    irq_oe_d = |status_d; // [RULE12]
    pins_oe_d = host_on; // [RULE10]
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_prev_q <= `GB_IRQ_ZERO;
      status_q <= `GB_IRQ_ZERO;
      irq_oe_q <= 1'b0;
      pins_oe_q <= 1'b0;
    end else begin
      irq_prev_q <= irq_prev_d;
      status_q <= status_d;
      irq_oe_q <= irq_oe_d;
      pins_oe_q <= pins_oe_d;
    end
  end

  assign o_periph = pins_q;
  assign o_pins_oe = pins_oe_q;
  assign o_acc_ack = ack_q;
  assign o_acc_rdata = rdata_q;
  assign o_irq_status = status_q;
  assign o_host_irq_out = 1'b0;
  assign o_host_irq_oe = irq_oe_q;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  one_select_a: assert property ($countones(~o_periph.sel_n) <= 1) // [RULE1]
    else $error("More than one peripheral select is low.");
  addr_stable_a: assert property (!(o_periph.rd_n && o_periph.wr_n) && $past(!(o_periph.rd_n && o_periph.wr_n))
    |-> $stable(o_periph.addr) && $stable(o_periph.dout) && $stable(o_periph.sel_n)) // [RULE16]
    else $error("Address, data or select moved under a strobe.");
  read_release_a: assert property (!o_periph.rd_n |-> !o_periph.doe && o_periph.wr_n) // [RULE3]
    else $error("Data driven or write strobe low during a read.");
  strobe_width_a: assert property ($fell(o_periph.rd_n && o_periph.wr_n)
    |-> !(o_periph.rd_n && o_periph.wr_n) [*4]) // [RULE4]
    else $error("Strobe shorter than the minimum width.");
  ready_pause_a: assert property (state_q == ST_IDLE && !ready_s |=> !(state_q == ST_SETUP && is_dma_q)) // [RULE5]
    else $error("Stream byte started while ready was low.");
  wait_hold_a: assert property (state_q == ST_STROBE && cnt_q == '0 && !wait_n_s && host_on
    |=> state_q == ST_STROBE && !(o_periph.rd_n && o_periph.wr_n)) // [RULE6]
    else $error("Cycle closed while wait was asserted.");
  host_first_a: assert property (state_q == ST_IDLE && i_acc_req && !ack_q && host_on
    |=> state_q == ST_SETUP && !is_dma_q ##3 !(o_periph.rd_n && o_periph.wr_n)) // [RULE15]
    else $error("Host access not started ahead of the stream.");
  irq_edge_a: assert property (irq_rise[0] && host_on |=> status_q[0] && o_host_irq_oe) // [RULE7]
    else $error("Interrupt edge not recorded.");
  irq_pin_a: assert property ((|o_irq_status) == o_host_irq_oe) // [RULE12]
    else $error("Host interrupt pin disagrees with status.");
  clear_one_a: assert property (status_q[1] && i_irq_clear[1] && !i_irq_set[1] && !irq_rise[1]
    |=> !status_q[1]) // [RULE13]
    else $error("Writing one did not clear a status bit.");
  float_a: assert property (!host_on |=> !o_pins_oe && !o_periph.doe && o_periph.sel_n == `GB_SEL_NONE) // [RULE10]
    else $error("Pins driven during host reset.");
endmodule

// [verification/periph_model.sv]
module periph_model (
  // Clock and bus pins from the master
  input wire logic i_clk,
  input wire gb_pkg::periph_pins_t i_pins,
  // Bench control
  input wire logic i_stall,
  // Answers to the master
  output logic [7:0] o_data,
  output logic o_wait_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import gb_pkg::*;
  logic [7:0] log_q [0:15];
  logic [3:0] sel_q [0:15];
  int log_n = 0;
  logic [7:0] last_q = 8'h00;
  periph_pins_t prev_q;
  logic reading;
  assign reading = !i_pins.rd_n && i_pins.sel_n != 4'hF;
  // A released bus shows the inverse of its last value, so stale data cannot pass for a good read.
  assign o_data = reading ? {5'h14, i_pins.addr} : ~last_q;
  assign o_wait_n = !(i_stall && (!i_pins.rd_n || !i_pins.wr_n));
  always @(posedge i_clk) begin
    prev_q <= i_pins;
    if (reading) begin
      last_q <= o_data;
    end
    if (!prev_q.wr_n && i_pins.wr_n && log_n < 16) begin
      log_q[log_n] <= prev_q.dout;
      sel_q[log_n] <= prev_q.sel_n;
      log_n <= log_n + 1;
    end
  end
endmodule

// [verification/guest_bus_master_port_tb.sv]
module guest_bus_master_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import gb_pkg::*;
  logic clk = 0, rst = 1, hrst_n = 1, req = 0, dma_en = 0, dvalid = 0, ready = 1, stall = 0;
  logic [1:0] irq = 2'h0, iclr = 2'h0, iset = 2'h0, status;
  logic [31:0] word = 32'h0;
  host_acc_t acc = '0;
  logic ack, dready, hirq, hirq_oe, pins_oe, wait_n;
  logic [7:0] rdata, pdata;
  periph_pins_t pins;
  int err_count = 0, comparisons = 0;
  int cyc, n0;
  always #10 clk = ~clk;

  guest_bus_master_port dut (.i_sys_clk(clk), .i_reset(rst), .i_host_reset_n(hrst_n),
    .i_acc_req(req), .i_acc(acc), .o_acc_ack(ack), .o_acc_rdata(rdata),
    .i_dma_en(dma_en), .i_dma_dev(2'h1), .i_dma_addr(3'h5), .i_dma_valid(dvalid),
    .i_dma_word(word), .o_dma_ready(dready), .i_irq_clear(iclr), .i_irq_set(iset),
    .o_irq_status(status), .o_host_irq_out(hirq), .o_host_irq_oe(hirq_oe), .o_periph(pins),
    .o_pins_oe(pins_oe), .i_periph_data(pdata), .i_periph_ready(ready), .i_periph_wait_n(wait_n),
    .i_periph_irq(irq));
  periph_model p (.i_clk(clk), .i_pins(pins), .i_stall(stall), .o_data(pdata), .o_wait_n(wait_n));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [1:0] dev, input logic [2:0] a, input logic [7:0] d);
    int k;
    acc = '{write: wr, dev: dev, addr: a, wdata: d};
    req = 1;
    for (k = 0; k < 100 && ack !== 1'b1; k++) step(1);
    cyc = k;
    req = 0;
    step(1);
  endtask

  task automatic t_writes();
    for (int d = 0; d < 4; d++) begin
      n0 = p.log_n;
      access(1'b1, 2'(d), 3'(d + 2), 8'(8'h30 + d));
      chk(cyc <= 10, 1);
      chk(p.log_q[n0], 8'(8'h30 + d));
      chk(p.sel_q[n0], 4'(~(4'h1 << d)));
    end
    $display("test writes done");
  endtask

  task automatic t_read_wait();
    stall = 1;
    fork
      access(1'b0, 2'h2, 3'h3, 8'h00);
      begin
        step(14);
        stall = 0;
      end
    join
    chk(cyc > 14, 1);
    chk(rdata, 8'hA3);
    $display("test read with wait done");
  endtask

  task automatic t_stream();
    ready = 0;
    dma_en = 1;
    // Let the low ready pass the synchroniser before the word arrives, or a byte starts early.
    step(3);
    word = 32'h44332211;
    dvalid = 1;
    step(1);
    dvalid = 0;
    n0 = p.log_n;
    step(30);
    chk(p.log_n, n0);
    ready = 1;
    for (int k = 0; k < 200 && p.log_n < n0 + 4; k++) step(1);
    for (int b = 0; b < 4; b++) begin
      chk(p.log_q[n0 + b], 8'(8'h11 * (b + 1)));
      chk(p.sel_q[n0 + b], 4'hD);
    end
    dma_en = 0;
    $display("test stream done");
  endtask

  task automatic t_irq();
    irq = 2'h1;
    step(6);
    chk(status, 2'h1);
    chk(hirq_oe, 1'b1);
    chk(hirq, 1'b0);
    iclr = 2'h1;
    step(1);
    iclr = 2'h0;
    step(3);
    chk(status, 2'h0);
    iset = 2'h2;
    step(1);
    iset = 2'h0;
    step(1);
    chk(status, 2'h2);
    iclr = 2'h2;
    step(1);
    iclr = 2'h0;
    irq = 2'h0;
    step(2);
    chk(hirq_oe, 1'b0);
    $display("test interrupts done");
  endtask

  task automatic t_host_reset();
    hrst_n = 0;
    step(5);
    chk(pins_oe, 1'b0);
    hrst_n = 1;
    step(7);
    chk(pins_oe, 1'b1);
    chk(pins.sel_n, 4'hF);
    $display("test host reset done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    step(8);
    rst = 0;
    step(6);
    t_writes();
    t_read_wait();
    t_stream();
    t_irq();
    t_host_reset();
    t_writes();
    print_verdict();
  end

  // The tests need a few hundred cycles, so this leaves a wide margin before a hang is cut.
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule
